// ===== src/fedrc_pkg.sv
package fedrc_pkg;

    // ******************************************
    // Register map and field layout
    // ******************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CAUSE_OFS = 8'h08;

    // Control register bits
    localparam int C_INX_EN = 0;
    localparam int C_INV_EN = 1;
    localparam int C_RM_LO = 2;
    localparam int C_OVF_FL = 4;
    localparam int C_UNF_FL = 5;
    localparam int C_GLOB = 6;
    localparam logic [31:0] CTRL_MASK = 32'h0000_007f;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Status register bits, software keeps the invalid flag
    localparam int S_AINX = 0;
    localparam int S_AINV = 1;
    localparam logic [31:0] STAT_MASK = 32'h0000_0003;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;

    // Cause register bits
    localparam int K_IOV = 0;
    localparam int K_INX = 1;
    localparam int K_DVZ = 2;
    localparam int K_UNF = 3;
    localparam int K_OVF = 4;
    localparam int K_ROP = 5;
    localparam int K_PRV = 6;
    localparam int K_UNI = 7;
    localparam logic [7:0] CAUSE_RST = 8'h00;
    localparam logic [7:0] CAUSE_UNI_ONLY = 8'h80;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ******************************************
    // Extended operand layout and result patterns
    // ******************************************
    localparam int SIGN_BIT = 79;
    localparam int EXP_HI = 78;
    localparam int EXP_LO = 64;
    localparam int LEAD_BIT = 63;
    localparam int FRAC_HI = 62;
    localparam logic [14:0] EXP_ONES = 15'h7fff;
    localparam logic [14:0] EXP_ZERO = 15'h0000;
    localparam logic [62:0] FRAC_ZERO = 63'h0;
    localparam logic [62:0] QNAN_FRAC = 63'h6000_0000_0000_0000;
    localparam logic [78:0] MAG_ZERO = 79'h0;
    localparam logic [47:0] INT_PAD = 48'h0;
    localparam logic [31:0] INT_POS_LARGE = 32'h7fff_ffff;
    localparam logic [31:0] INT_NEG_LARGE = 32'h8000_0000;
    localparam logic [31:0] INT_ZERO = 32'h0000_0000;
    localparam logic [31:0] CMP_UNORD = 32'h0003_fe00;
    localparam logic [79:0] VAL_ZERO = 80'h0;

    localparam logic [1:0] RM_NEAR = 2'b00;
    localparam logic [1:0] RM_ZERO = 2'b01;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CVT, OP_CMP, OP_CMPU,
        OP_FLT, OP_INT, OP_NINT, OP_TRNC, OP_SQRT
    } fedrc_op_t;

    typedef enum logic [2:0] {
        CL_ZERO, CL_NORM, CL_INF, CL_QNAN, CL_SNAN, CL_DEN, CL_UNN
    } fedrc_class_t;

    typedef enum logic [2:0] {
        DR_NONE, DR_QNAN, DR_ZERO, DR_INF, DR_BIGINT, DR_INTZERO, DR_UNORD
    } fedrc_def_t;

    typedef struct packed {
        logic valid;
        fedrc_op_t op;
        logic [79:0] srcA;
        logic [79:0] srcB;
        logic resSign;
        logic overflow;
        logic underflow;
        logic inexact;
        logic intRange;
        logic privViol;
    } fedrc_req_t;

    typedef struct packed {
        logic valid;
        logic trap;
        logic [7:0] cause;
        fedrc_def_t kind;
        logic [79:0] value;
        logic [1:0] roundMode;
    } fedrc_resp_t;

endpackage : fedrc_pkg

// ===== src/fedrc_top.sv
// Notes on behaviour
// RULE1 - Infinite operands in valid operations give IEEE results with no exception.
// RULE2 - Infinity operands set reserved-operand only for IEEE-invalid operations.
// RULE3 - A newly created infinite result raises the overflow cause and trap.
// RULE4 - Inexact with trap disabled sets accumulated inexact, no trap.
// RULE5 - Inexact with trap enabled sets cause and accumulated flag, then traps.
// RULE6 - Integer conversion overflow only when value misses signed 32-bit range.
// RULE7 - Unnormalized extended source sets reserved-operand cause and traps.
// RULE8 - Control register holds overflow, underflow and global default-result bits.
// RULE9 - Covered conditions give default results; others trap with causes recorded.
// RULE10 - Privilege violation and unimplemented opcode always trap.
// RULE11 - Only the inexact trap enable influences the trap decision.
// RULE12 - Overflow flush replaces overflow with correctly signed infinity.
// RULE13 - Underflow flush replaces underflow with signed zero, never denormal.
// RULE14 - Suppressed conditions write an operation-dependent default to destination.
// RULE15 - Multiply/divide default sign is sign xor; conversion keeps source sign.
// RULE16 - Add/subtract defaults are signed correctly, but quiet NaNs are positive.
// RULE17 - The only NaN produced is the universal quiet NaN pattern.
// RULE18 - Default mode uses configured rounding; overflow rounds nearest; ops choose.
// RULE19 - Global mode ordered compare on odd operands yields unordered, no trap.
// RULE20 - Unordered compare on odd operands sets reserved-operand cause and traps.
// RULE21 - Global mode denormal source gives quiet NaN, or zero for integers.
// RULE22 - Extended zero exponent with leading one counts as denormalized.
// RULE23 - Accumulated flags under default-result mode are undefined.
// RULE24 - With unimplemented cause set, other causes are undefined.
// RULE25 - Cause register updates in the same cycle the trap is signalled.
`timescale 1ns/1ps
module fedrc_top import fedrc_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire fedrc_req_t opReq,
    output fedrc_resp_t opResp
);

    // ******************************************
    // Helper functions
    // ******************************************

    // Rule-of-thumb classifier for an extended operand
    function automatic fedrc_class_t classify(input logic [79:0] v);
        logic [14:0] e;
        logic l;
        logic [62:0] f;
        e = v[EXP_HI:EXP_LO];
        l = v[LEAD_BIT];
        f = v[FRAC_HI:0];
        if (e == EXP_ZERO) begin
            // Zero exponent with leading one is denormal, see RULE22
            classify = (l || f != FRAC_ZERO) ? CL_DEN : CL_ZERO;
        end else if (e == EXP_ONES) begin
            if (f == FRAC_ZERO) begin
                classify = CL_INF;
            end else begin
                classify = f[FRAC_HI] ? CL_QNAN : CL_SNAN;
            end
        end else begin
            classify = l ? CL_NORM : CL_UNN;
        end
    endfunction : classify

    // NaN, denormal or unnormal
    function automatic logic isOdd(input fedrc_class_t c);
        isOdd = (c == CL_QNAN) || (c == CL_SNAN) || (c == CL_DEN) || (c == CL_UNN);
    endfunction : isOdd

    function automatic logic [31:0] mergeStrb(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb
    );
        mergeStrb = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                mergeStrb[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : mergeStrb

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == CAUSE_OFS);
    endfunction : isMapped

    // ******************************************
    // Register bus slave
    // ******************************************
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [31:0] floatControlReg;
    logic [31:0] floatStatusReg;
    logic [7:0] floatExceptionCauseReg;

    // Address and data are taken in either order, one write at a time
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign arready = !rvalid;

    wire awFire = awvalid && awready;
    wire wFire = wvalid && wready;
    wire arFire = arvalid && arready;
    wire doWrite = awHeld && wHeld;
    wire wrCtrl = doWrite && (awAddr == CTRL_OFS);
    wire wrStat = doWrite && (awAddr == STAT_OFS);
    wire wrCause = doWrite && (awAddr == CAUSE_OFS);

    // Read mux, unmapped addresses read zero
    wire [31:0] rdSel = (araddr == CTRL_OFS) ? floatControlReg :
                        (araddr == STAT_OFS) ? floatStatusReg :
                        (araddr == CAUSE_OFS) ? {24'h0, floatExceptionCauseReg} :
                        INT_ZERO;

    // Write channel capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= CTRL_OFS;
            wData <= INT_ZERO;
            wStrb <= 4'h0;
        end else begin
            awHeld <= awFire ? 1'b1 : (doWrite ? 1'b0 : awHeld);
            wHeld <= wFire ? 1'b1 : (doWrite ? 1'b0 : wHeld);
            if (awFire) begin
                awAddr <= awaddr;
            end
            if (wFire) begin
                wData <= wdata;
                wStrb <= wstrb;
            end
        end
    end

    // Responses stand until the master takes them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= INT_ZERO;
        end else begin
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (arFire) begin
                rvalid <= 1'b1;
                rdata <= rdSel;
                rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ******************************************
    // Operand classification
    // ******************************************
    wire fedrc_op_t op = opReq.op;
    wire fedrc_class_t clA = classify(opReq.srcA);
    wire fedrc_class_t clB = classify(opReq.srcB);
    wire sA = opReq.srcA[SIGN_BIT];
    wire sB = opReq.srcB[SIGN_BIT];

    wire isAddSub = (op == OP_ADD) || (op == OP_SUB);
    wire isMul = (op == OP_MUL);
    wire isDiv = (op == OP_DIV);
    wire isCvt = (op == OP_CVT);
    wire isCmp = (op == OP_CMP) || (op == OP_CMPU);
    wire isFlt = (op == OP_FLT);
    wire isToInt = (op == OP_INT) || (op == OP_NINT) || (op == OP_TRNC);
    wire twoSrc = isAddSub || isMul || isDiv || isCmp;
    wire arith = isAddSub || isMul || isDiv || isCvt;

    wire infA = twoSrc && (clA == CL_INF);
    wire infB = (clB == CL_INF);
    wire zeroA = (clA == CL_ZERO);
    wire zeroB = (clB == CL_ZERO);

    // Control fields
    wire inxEn = floatControlReg[C_INX_EN];
    wire ovfFlush = floatControlReg[C_OVF_FL];
    wire unfFlush = floatControlReg[C_UNF_FL];
    wire glob = floatControlReg[C_GLOB];
    wire [1:0] cfgRound = floatControlReg[C_RM_LO +: 2];

    // ******************************************
    // Condition detection
    // ******************************************

    // Infinities are legal except in the invalid forms, see RULE1 and RULE2
    wire effSub = sA ^ sB ^ (op == OP_SUB);
    wire invAdd = isAddSub && infA && infB && effSub;
    wire invMul = isMul && ((zeroA && infB) || (infA && zeroB));
    wire invDiv = isDiv && ((infA && infB) || (zeroA && zeroB));
    wire invalidOp = invAdd || invMul || invDiv;

    // Unnormal or other odd sources are reserved operands, see RULE7
    wire oddSrc = (twoSrc && isOdd(clA)) || (!isFlt && isOdd(clB));
    wire ropC = !isFlt && (oddSrc || invalidOp);

    // Overflow only for a new infinity, not one carried through, see RULE3
    wire ovfC = arith && opReq.overflow && !infA && !infB && !ropC;
    wire unfC = arith && opReq.underflow && !ropC;
    wire dvzC = isDiv && zeroB && (zeroA || clA == CL_NORM);
    wire inxC = (arith || isToInt || isFlt) && opReq.inexact && !ropC;
    wire iovC = isToInt && opReq.intRange && !ropC; // see RULE6
    wire uniC = (op > OP_TRNC);
    wire prvC = opReq.privViol;

    // ******************************************
    // Trap decision
    // ******************************************

    // Flush bits block the matching trap, see RULE8 and RULE9
    wire ovfBlk = ovfFlush || glob;
    wire unfBlk = unfFlush || glob;
    wire ropBlk = glob && (op != OP_CMPU); // see RULE19 and RULE20

    wire tOvf = ovfC && !ovfBlk;
    wire tUnf = unfC && !unfBlk;
    wire tRop = ropC && !ropBlk;
    wire tDvz = dvzC && !glob;
    wire tIov = iovC && !glob;
    // Invalid and other enables are never looked at, see RULE11
    wire tInx = inxC && inxEn && !glob; // see RULE5

    // Nothing masks these two, see RULE10
    wire hardTrap = uniC || prvC;
    wire trapNow = opReq.valid && (hardTrap || tOvf || tUnf || tRop || tDvz || tIov || tInx);

    // Unimplemented hides the rest, so clear them, see RULE24
    wire [7:0] rawCause = {uniC, prvC, tRop, tOvf, tUnf, tDvz, tInx, tIov};
    wire [7:0] causeNow = uniC ? CAUSE_UNI_ONLY : rawCause;

    // ******************************************
    // Default result selection
    // ******************************************
    wire srcNan = (clB == CL_QNAN) || (clB == CL_SNAN);
    wire fedrc_def_t kindNow =
        (!opReq.valid || trapNow) ? DR_NONE :
        (op == OP_CMP && ropC && glob) ? DR_UNORD : // see RULE19
        (ropC && glob && isToInt) ? (srcNan ? DR_BIGINT : DR_INTZERO) : // see RULE21
        (ropC && glob) ? DR_QNAN : // see RULE21
        (dvzC && glob) ? DR_INF :
        (iovC && glob) ? DR_BIGINT :
        (ovfC && ovfBlk) ? DR_INF : // see RULE12
        (unfC && unfBlk) ? DR_ZERO : // see RULE13
        DR_NONE;

    // Sign rules per operation class, see RULE15 and RULE16
    wire signNow = (isMul || isDiv) ? (sA ^ sB) :
                   (isToInt || isCvt) ? sB :
                   (kindNow == DR_QNAN) ? 1'b0 :
                   opReq.resSign;

    // Default value image for the destination, see RULE14
    wire [79:0] valueNow =
        (kindNow == DR_QNAN) ? {signNow, EXP_ONES, 1'b1, QNAN_FRAC} : // see RULE17
        (kindNow == DR_INF) ? {signNow, EXP_ONES, 1'b0, FRAC_ZERO} :
        (kindNow == DR_ZERO) ? {signNow, MAG_ZERO} :
        (kindNow == DR_BIGINT) ? {INT_PAD, signNow ? INT_NEG_LARGE : INT_POS_LARGE} :
        (kindNow == DR_UNORD) ? {INT_PAD, CMP_UNORD} :
        VAL_ZERO;

    // Overflow in a flush mode rounds nearest so the default is infinity
    wire [1:0] roundSel = (op == OP_NINT || (ovfC && ovfBlk)) ? RM_NEAR : // see RULE18
                          (op == OP_TRNC) ? RM_ZERO :
                          cfgRound;

    // ******************************************
    // Response and registers
    // ******************************************

    // Inexact reaches the accumulated flag unless a privilege or unimplemented trap is taken, see RULE4 and RULE5
    wire setAinx = opReq.valid && inxC && !hardTrap;
    wire [31:0] statWr = wrStat ? mergeStrb(floatStatusReg, wData, wStrb) : floatStatusReg;
    // Hardware set wins over a software clear; flag not kept exact, see RULE23
    wire [31:0] next_status = (statWr & STAT_MASK) | (setAinx ? 32'h1 << S_AINX : INT_ZERO);
    wire [31:0] next_ctrl = wrCtrl ? (mergeStrb(floatControlReg, wData, wStrb) & CTRL_MASK)
                                   : floatControlReg;
    wire [31:0] causeWr = mergeStrb({24'h0, floatExceptionCauseReg}, wData, wStrb);
    wire [7:0] next_cause = trapNow ? causeNow : // see RULE25
                            wrCause ? causeWr[7:0] : floatExceptionCauseReg;

    // Register file
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            floatControlReg <= CTRL_RST;
            floatStatusReg <= STAT_RST;
            floatExceptionCauseReg <= CAUSE_RST;
        end else begin
            floatControlReg <= next_ctrl;
            floatStatusReg <= next_status;
            floatExceptionCauseReg <= next_cause;
        end
    end

    // Response one cycle after the request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            opResp <= '0;
        end else begin
            opResp.valid <= opReq.valid;
            opResp.trap <= trapNow;
            opResp.cause <= trapNow ? causeNow : CAUSE_RST;
            opResp.kind <= kindNow;
            opResp.value <= valueNow;
            opResp.roundMode <= roundSel;
        end
    end

    // ******************************************
    // Assertions
    // ******************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence wrJoined;
        awHeld && wHeld;
    endsequence
    sequence wrAnswered;
        bvalid && bresp == (isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR);
    endsequence
    sequence inxSeen;
        opReq.valid && inxC && !hardTrap;
    endsequence

    axi_write_a: assert property (wrJoined |=> wrAnswered)
        else $error("write not answered");
    unimpl_trap_a: assert property ( // see RULE10
        opReq.valid && uniC |=> opResp.trap && opResp.cause == CAUSE_UNI_ONLY)
        else $error("unimplemented op did not trap alone");
    priv_trap_a: assert property ( // see RULE10
        opReq.valid && prvC && glob && !uniC |=> opResp.trap && opResp.cause[K_PRV])
        else $error("privilege violation masked");
    inx_quiet_a: assert property ( // see RULE4
        inxSeen ##0 !inxEn |=> !opResp.cause[K_INX] && floatStatusReg[S_AINX])
        else $error("disabled inexact misbehaved");
    inx_trap_a: assert property ( // see RULE5
        inxSeen ##0 (inxEn && !glob) |=> opResp.trap && opResp.cause[K_INX]
            && floatStatusReg[S_AINX])
        else $error("enabled inexact did not trap");
    cause_sync_a: assert property ( // see RULE25
        opResp.trap |-> floatExceptionCauseReg == opResp.cause && $past(opReq.valid))
        else $error("cause register out of step with trap");
    ovf_flush_a: assert property ( // see RULE12
        opReq.valid && ovfC && ovfFlush && !unfC && !trapNow |=> !opResp.trap
            && opResp.value[EXP_HI:EXP_LO] == EXP_ONES && opResp.roundMode == RM_NEAR)
        else $error("overflow flush not infinity");
    unf_flush_a: assert property ( // see RULE13
        opReq.valid && unfC && unfFlush && !ovfC && !hardTrap && !tRop && !tDvz
            && !tIov && !tInx |=> opResp.kind == DR_ZERO
            && opResp.value[EXP_HI:0] == MAG_ZERO)
        else $error("underflow flush not zero");
    fcmp_unord_a: assert property ( // see RULE19
        opReq.valid && op == OP_CMP && ropC && glob && !prvC |=> !opResp.trap
            && opResp.value[31:0] == CMP_UNORD)
        else $error("ordered compare trapped");
    fcmpu_trap_a: assert property ( // see RULE20
        opReq.valid && op == OP_CMPU && ropC |=> opResp.trap && opResp.cause[K_ROP])
        else $error("unordered compare did not trap");
    qnan_shape_a: assert property ( // see RULE17
        opReq.valid && kindNow == DR_QNAN |=>
            opResp.value[EXP_HI:0] == {EXP_ONES, 1'b1, QNAN_FRAC})
        else $error("bad quiet NaN pattern");
    inf_legal_a: assert property ( // see RULE1
        opReq.valid && arith && (infA || infB) && !invalidOp && !isOdd(clA)
            && !isOdd(clB) |=> !opResp.cause[K_OVF] && !opResp.cause[K_ROP])
        else $error("valid infinity raised a cause");

endmodule : fedrc_top

// ===== sim/fedrc_top_tb.sv
`timescale 1ns/1ps
module fedrc_top_tb import fedrc_pkg::*; ;
    // Operand images and request flag masks {resSign,ovf,unf,inx,range,priv}
    localparam logic [79:0] NRM = {1'b0, 15'h3fff, 1'b1, 63'h0};
    localparam logic [79:0] NNRM = {1'b1, 15'h3fff, 1'b1, 63'h0};
    localparam logic [79:0] ZRO = 80'h0;
    localparam logic [79:0] PINF = {1'b0, EXP_ONES, 1'b0, FRAC_ZERO};
    localparam logic [79:0] DEN = 80'h1;
    localparam logic [79:0] DEN1 = {16'h0, 1'b1, 63'h0};
    localparam logic [79:0] UNN = {1'b0, 15'h3fff, 1'b0, 63'h5};
    localparam logic [79:0] QN = {1'b0, EXP_ONES, 1'b1, QNAN_FRAC};
    localparam logic [79:0] BIGN = {1'b1, 15'h403f, 1'b1, 63'h0};
    logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, sg;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdv, cv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    fedrc_req_t opReq;
    fedrc_resp_t opResp;
    fedrc_op_t ro[4] = '{OP_NINT, OP_TRNC, OP_INT, OP_ADD};
    logic [1:0] re[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    int errors, cmp_count, n;

    fedrc_top i_dut (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .opReq(opReq), .opResp(opResp));

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ******************************************
    // Expectation helpers and bus tasks
    // ******************************************
    function automatic logic [79:0] inf(input logic s);
        return {s, EXP_ONES, 1'b0, FRAC_ZERO};
    endfunction : inf

    function automatic logic [79:0] qnan(input logic s);
        return {s, EXP_ONES, 1'b1, QNAN_FRAC};
    endfunction : qnan

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Address and data are released separately, each at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        tr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            rdv = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    // One request, answer checked a cycle later; a non-zero cause means a trap
    task automatic op(input fedrc_op_t o, input logic [79:0] a, input logic [79:0] b,
            input logic [5:0] f, input logic [7:0] c, input fedrc_def_t k, input logic [79:0] v);
        @(posedge clk);
        opReq <= '{1'b1, o, a, b, f[5], f[4], f[3], f[2], f[1], f[0]};
        @(posedge clk);
        opReq.valid <= 1'b0;
        @(negedge clk);
        chk(80'(opResp.valid), 80'h1);
        chk(80'(opResp.trap), 80'(c != 8'h00));
        chk(80'(opResp.cause), 80'(c));
        if (c == 8'h00) chk(80'(opResp.kind), 80'(k));
        if (c == 8'h00 && k != DR_NONE) chk(opResp.value, v);
    endtask : op

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        errors++;
        summarize();
    end

    // ******************************************
    // Test sequence
    // ******************************************
    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
        opReq = '0;
        errors = 0;
        cmp_count = 0;
        void'($urandom(32'h0507));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (n = 0; n < 3; n++) begin
            rd(8'(n * 4));
            chk(80'(rdv), 80'h0);
        end
        rd(8'h0c);
        chk(80'({rsp, rdv}), 80'({RESP_SLVERR, 32'h0}));
        wr(8'h0c, 32'hffff_ffff);
        chk(80'(rsp), 80'(RESP_SLVERR));
        $display("register test done");
        op(OP_MUL, PINF, NRM, 6'h00, 8'h00, DR_NONE, 80'h0);
        op(OP_ADD, PINF, PINF, 6'h00, 8'h00, DR_NONE, 80'h0);
        op(OP_MUL, ZRO, PINF, 6'h00, 8'h20, DR_NONE, 80'h0);
        op(OP_DIV, PINF, inf(1'b1), 6'h00, 8'h20, DR_NONE, 80'h0);
        op(OP_ADD, PINF, inf(1'b1), 6'h00, 8'h20, DR_NONE, 80'h0);
        op(OP_SUB, PINF, PINF, 6'h00, 8'h20, DR_NONE, 80'h0);
        op(OP_ADD, NRM, NRM, 6'h10, 8'h10, DR_NONE, 80'h0);
        rd(CAUSE_OFS);
        chk(80'(rdv), 80'h10);
        op(OP_INT, ZRO, NRM, 6'h02, 8'h01, DR_NONE, 80'h0);
        op(OP_NINT, ZRO, NRM, 6'h00, 8'h00, DR_NONE, 80'h0);
        op(OP_ADD, UNN, NRM, 6'h00, 8'h20, DR_NONE, 80'h0);
        op(OP_ADD, NRM, NRM, 6'h08, 8'h08, DR_NONE, 80'h0);
        op(OP_SQRT, NRM, NRM, 6'h00, 8'h80, DR_NONE, 80'h0);
        wr(CTRL_OFS, 32'h2);
        op(OP_ADD, NRM, NRM, 6'h04, 8'h00, DR_NONE, 80'h0);
        rd(STAT_OFS);
        chk(80'(rdv[S_AINX]), 80'h1);
        wr(CTRL_OFS, 32'h1);
        op(OP_FLT, ZRO, ZRO, 6'h04, 8'h02, DR_NONE, 80'h0);
        op(OP_ADD, NRM, NRM, 6'h04, 8'h02, DR_NONE, 80'h0);
        rd(CAUSE_OFS);
        chk(80'(rdv), 80'h02);
        $display("trap test done");
        wr(CTRL_OFS, 32'h10);
        op(OP_MUL, NNRM, NRM, 6'h10, 8'h00, DR_INF, inf(1'b1));
        op(OP_CVT, ZRO, NNRM, 6'h10, 8'h00, DR_INF, inf(1'b1));
        op(OP_ADD, NRM, NRM, 6'h08, 8'h08, DR_NONE, 80'h0);
        wr(CTRL_OFS, 32'h20);
        op(OP_ADD, NRM, NNRM, 6'h28, 8'h00, DR_ZERO, {1'b1, MAG_ZERO});
        op(OP_ADD, NRM, NRM, 6'h10, 8'h10, DR_NONE, 80'h0);
        $display("flush test done");
        wr(CTRL_OFS, 32'h41);
        op(OP_ADD, DEN, NRM, 6'h20, 8'h00, DR_QNAN, qnan(1'b0));
        op(OP_MUL, NNRM, DEN, 6'h00, 8'h00, DR_QNAN, qnan(1'b1));
        op(OP_ADD, DEN1, NRM, 6'h00, 8'h00, DR_QNAN, qnan(1'b0));
        op(OP_INT, ZRO, DEN, 6'h00, 8'h00, DR_INTZERO, {INT_PAD, INT_ZERO});
        op(OP_CMP, QN, NRM, 6'h00, 8'h00, DR_UNORD, {INT_PAD, CMP_UNORD});
        op(OP_CMPU, QN, NRM, 6'h00, 8'h20, DR_NONE, 80'h0);
        op(OP_SQRT, NRM, NRM, 6'h00, 8'h80, DR_NONE, 80'h0);
        op(OP_ADD, NRM, NRM, 6'h01, 8'h40, DR_NONE, 80'h0);
        op(OP_MUL, ZRO, PINF, 6'h00, 8'h00, DR_QNAN, qnan(1'b0));
        op(OP_DIV, NRM, ZRO, 6'h00, 8'h00, DR_INF, PINF);
        op(OP_TRNC, ZRO, BIGN, 6'h02, 8'h00, DR_BIGINT, {INT_PAD, INT_NEG_LARGE});
        $display("global mode test done");
        wr(CTRL_OFS, 32'h08);
        for (n = 0; n < 4; n++) begin
            op(ro[n], ZRO, NRM, 6'h00, 8'h00, DR_NONE, 80'h0);
            chk(80'(opResp.roundMode), 80'(re[n]));
        end
        $display("rounding test done");
        // Random control words with overflowing operands, random ones only under overflow flush or global mode
        repeat (24) begin
            cv = $urandom();
            sg = 1'($urandom());
            wr(CTRL_OFS, cv);
            rd(CTRL_OFS);
            chk(80'(rdv), 80'(cv & CTRL_MASK));
            if (cv[C_OVF_FL] | cv[C_GLOB]) begin
                op(OP_ADD, {1'b0, 15'($urandom() % 32'h7ffe + 1), 1'b1, 63'($urandom())}, NRM,
                    {sg, 5'h10}, 8'h00, DR_INF, inf(sg));
                chk(80'(opResp.roundMode), 80'(RM_NEAR));
            end else begin
                op(OP_ADD, NRM, NRM, {sg, 5'h10}, 8'h10, DR_NONE, 80'h0);
            end
        end
        $display("random test done");
        summarize();
    end
endmodule : fedrc_top_tb
